/* logic/standby_defs.svh */
// Constants for the standby and oscillator settling block.
// Assumes one 10 MHz clock that also stands in for the crystal clock.
`ifndef STANDBY_DEFS_SVH
`define STANDBY_DEFS_SVH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define ADDR_SETTLE_STATUS 16'hffa3
`define ADDR_SETTLE_SELECT 16'hffa4

// ----------------------------------------
// Reset values and field positions
// ----------------------------------------
`define SETTLE_STATUS_RESET 8'h00
`define SETTLE_SELECT_RESET 3'h5
`define SELECT_FIELD_MSB    2

// ----------------------------------------
// Thresholds as exponents of crystal periods, then the counter width
// ----------------------------------------
`define EXP_2E11 5'd11
`define EXP_2E13 5'd13
`define EXP_2E14 5'd14
`define EXP_2E15 5'd15
`define EXP_2E16 5'd16
`define COUNT_W  17

`endif

/* logic/standby_pkg.sv */
// Types for the standby and oscillator settling block.
// Assumes the constants header is included by the modules.
package standby_pkg;

  // Power state, Gray coded along run->halt, stop->wait and wait->run; run->stop changes both bits
  typedef enum logic [1:0] {
    ST_RUN  = 2'b00,
    ST_HALT = 2'b01,
    ST_STOP = 2'b11,
    ST_WAIT = 2'b10
  } pwr_state_t;

  // Processor register access from the core
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } reg_req_t;

  // Clock gating outputs
  typedef struct packed {
    logic cpu_clk_en;
    logic hs_osc_en;
    logic int_osc_en;
  } clk_ctl_t;

endpackage

/* logic/settle_counter.sv */
// Crystal settling counter with thermometer status.
// Assumes crystal_running says when the crystal truly oscillates.
`timescale 1ns/1ps
`include "standby_defs.svh"
module settle_counter
  import standby_pkg::*;
#(
  parameter int W = `COUNT_W
) (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       nrst,
  // Control
  input  wire logic       restart,
  input  wire logic       crystal_running,
  input  wire logic [4:0] limit_exp,
  // Status
  output logic [4:0]      therm_q
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [W-1:0] cnt;
    logic [4:0]   therm;
  } cnt_state_t;

  cnt_state_t s_q;  // Registered state
  cnt_state_t s_d;  // Next state

  // Threshold reached test, shared by all five bits
  function automatic logic reached(input logic [W-1:0] c, input logic [4:0] e);
    reached = (c >> e) != '0;
  endfunction

  localparam logic [4:0] EXPS [5] = '{`EXP_2E11, `EXP_2E13, `EXP_2E14,
                                      `EXP_2E15, `EXP_2E16};

  // Next state: count while running, stop at selected limit
  always_comb begin
    s_d = s_q;
    if (restart) begin
      s_d = '0;
    end else if (crystal_running && !reached(s_q.cnt, limit_exp)) begin
      s_d.cnt = s_q.cnt + 1'b1;
    end
    if (!restart) begin
      for (int i = 0; i < 5; i++) begin
        // Bit 4 is the shortest threshold; bits are set here and cleared only by restart
        if (reached(s_q.cnt, EXPS[i]) && EXPS[i] <= limit_exp) begin
          s_d.therm[4-i] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign therm_q = s_q.therm;

endmodule

/* logic/standby_ctl.sv */
// Standby controller: halt and stop states, oscillator settling wait,
// settling status and wait-select registers on the core's byte bus.
// Assumes core issues one-cycle halt/stop pulses and byte accesses.
`timescale 1ns/1ps
`include "standby_defs.svh"
module standby_ctl
  import standby_pkg::*;
(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       nrst,
  // Core instruction events
  input  wire logic       halt_instr,
  input  wire logic       stop_instr,
  input  wire logic       irq_pending,
  input  wire logic       cpu_on_crystal,
  input  wire logic       cpu_on_main,
  // Oscillator control
  input  wire logic       main_osc_stop,
  input  wire logic       crystal_running,
  // Register access
  input  reg_req_t        req,
  output logic [7:0]      rdata_q,
  // Clock control outputs
  output clk_ctl_t        clk_q,
  output logic            wait_busy_q
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    pwr_state_t st;
    logic [2:0] sel;
    logic [7:0] rdata;
    clk_ctl_t   clk;
    logic       busy;
    logic       main_osc_stop_prev;
  } ctl_state_t;

  ctl_state_t s_q;   // Registered state
  ctl_state_t s_d;   // Next state
  logic [4:0] therm; // Settling status thermometer
  logic       clr;   // Status clear pulse

  // Select code to exponent; prohibited codes fall to longest wait
  function automatic logic [4:0] sel_exp(input logic [2:0] c);
    case (c)
      3'h1:    sel_exp = `EXP_2E11;
      3'h2:    sel_exp = `EXP_2E13;
      3'h3:    sel_exp = `EXP_2E14;
      3'h4:    sel_exp = `EXP_2E15;
      default: sel_exp = `EXP_2E16;
    endcase
  endfunction

  // Status is full when bit for the selected threshold is set
  function automatic logic done(input logic [4:0] t, input logic [2:0] c);
    case (c)
      3'h1:    done = t[4];
      3'h2:    done = t[3];
      3'h3:    done = t[2];
      3'h4:    done = t[1];
      default: done = t[0];
    endcase
  endfunction

  // Stop only honoured from the main clock
  logic stop_ok;
  assign stop_ok = stop_instr && cpu_on_main;

  // Clear on stop entry or rising oscillator-stop bit
  assign clr = (stop_ok && s_q.st == ST_RUN) ||
               (main_osc_stop && !s_q.main_osc_stop_prev);

  // ----------------------------------------
  // Settling counter
  // ----------------------------------------
  settle_counter #(
    .W (`COUNT_W)
  ) u_cnt (
    .clock           (clock),
    .nrst            (nrst),
    .restart         (clr),
    // Crystal is stopped in stop, so no counting there
    .crystal_running (crystal_running && !main_osc_stop && s_q.clk.hs_osc_en),
    .limit_exp       (sel_exp(s_q.sel)),
    .therm_q         (therm)
  );

  // Next state: power states, registers, read data
  always_comb begin
    s_d = s_q;
    s_d.main_osc_stop_prev = main_osc_stop;
    case (s_q.st)
      ST_RUN: begin
        if (stop_ok) begin
          s_d.st = ST_STOP;
        end else if (halt_instr) begin
          s_d.st = ST_HALT;
        end
      end
      ST_HALT: begin
        if (irq_pending) begin
          s_d.st = ST_RUN;
        end
      end
      ST_STOP: begin
        if (irq_pending) begin
          // Internal-clock users run at once and poll status
          s_d.st = cpu_on_crystal ? ST_WAIT : ST_RUN;
        end
      end
      default: begin
        if (done(therm, s_q.sel)) begin
          s_d.st = ST_RUN;
        end
      end
    endcase
    // Oscillators off only in stop; subclock is never touched here
    s_d.clk.cpu_clk_en = (s_d.st == ST_RUN);
    s_d.clk.hs_osc_en  = (s_d.st != ST_STOP);
    s_d.clk.int_osc_en = (s_d.st != ST_STOP);
    s_d.busy = (s_d.st == ST_WAIT);
    // Byte write of select; upper bits dropped
    if (req.wr && req.addr == `ADDR_SETTLE_SELECT) begin
      s_d.sel = req.wdata[`SELECT_FIELD_MSB:0];
    end
    // Read mux; unmapped reads return zero
    if (req.rd && req.addr == `ADDR_SETTLE_STATUS) begin
      s_d.rdata = {3'h0, therm};
    end else if (req.rd && req.addr == `ADDR_SETTLE_SELECT) begin
      s_d.rdata = {5'h00, s_q.sel};
    end else begin
      s_d.rdata = 8'h00;
    end
  end

  // State register; halt/stop hold registers by gating only
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s_q.st         <= ST_RUN;
      s_q.sel        <= `SETTLE_SELECT_RESET;
      s_q.rdata      <= `SETTLE_STATUS_RESET;
      s_q.clk        <= 3'b111;
      s_q.busy       <= 1'b0;
      s_q.main_osc_stop_prev <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata_q     = s_q.rdata;
  assign clk_q       = s_q.clk;
  assign wait_busy_q = s_q.busy;

endmodule

/* test/standby_ctl_assertions.sv */
// Port-level checker for the standby controller.
// Assumes one clock and the active-low asynchronous reset of the controller.
`timescale 1ns/1ps
module standby_ctl_checker
  import standby_pkg::*;
(
  // Clock and reset
  input wire logic       clock,
  input wire logic       nrst,
  // Core events
  input wire logic       halt_instr,
  input wire logic       stop_instr,
  input wire logic       irq_pending,
  input wire logic       cpu_on_crystal,
  input wire logic       cpu_on_main,
  // Oscillator control
  input wire logic       main_osc_stop,
  input wire logic       crystal_running,
  // Register access and outputs
  input wire reg_req_t   req,
  input wire logic [7:0] rdata_q,
  input wire clk_ctl_t   clk_q,
  input wire logic       wait_busy_q
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  // One domain, so clock and reset are given once
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  halt_gate_a: assert property (halt_instr && !stop_instr && clk_q.cpu_clk_en && !irq_pending
    |=> !clk_q.cpu_clk_en && clk_q.hs_osc_en && clk_q.int_osc_en) else $error("halt gating");
  stop_osc_a: assert property (stop_instr && cpu_on_main && clk_q.cpu_clk_en
    |=> clk_q == 3'h0) else $error("stop gating");
  stop_hold_a: assert property (!clk_q.hs_osc_en && !irq_pending
    |=> !clk_q.hs_osc_en) else $error("stop left early");
  stop_refused_a: assert property (stop_instr && !cpu_on_main && clk_q.cpu_clk_en
    |=> clk_q.hs_osc_en) else $error("stop off main");
  stop_wake_a: assert property (!clk_q.hs_osc_en && irq_pending
    |=> clk_q.hs_osc_en) else $error("no wake");
  busy_hold_a: assert property (wait_busy_q |-> !clk_q.cpu_clk_en)
    else $error("cpu runs in wait");
  wait_end_a: assert property ($fell(wait_busy_q) |-> clk_q.cpu_clk_en)
    else $error("wait end");
  status_top_a: assert property ($past(req.rd) && $past(req.addr) == 16'hffa3
    |-> rdata_q[7:5] == 3'h0) else $error("status top bits");
  select_top_a: assert property ($past(req.rd) && $past(req.addr) == 16'hffa4
    |-> rdata_q[7:3] == 5'h00) else $error("select top bits");
endmodule

bind standby_ctl standby_ctl_checker standby_ctl_checker_inst (.clock(clock), .nrst(nrst),
  .halt_instr(halt_instr), .stop_instr(stop_instr), .irq_pending(irq_pending),
  .cpu_on_crystal(cpu_on_crystal), .cpu_on_main(cpu_on_main), .main_osc_stop(main_osc_stop),
  .crystal_running(crystal_running), .req(req), .rdata_q(rdata_q), .clk_q(clk_q),
  .wait_busy_q(wait_busy_q));

/* test/standby_ctl_bench.sv */
// Self-checking bench for the standby controller.
// Assumes the controller alone; inputs change at the falling edge.
`timescale 1ns/1ps
module standby_ctl_bench;
  import standby_pkg::*;
  // Stimulus and observed outputs
  logic       clock, nrst, halt_instr, stop_instr, irq_pending;
  logic       cpu_on_crystal, cpu_on_main, main_osc_stop, crystal_running;
  reg_req_t   req;
  logic [7:0] rdata_q;
  clk_ctl_t   clk_q;
  logic       wait_busy_q;
  int         miscompares, num_checks, cycles;
  // Expected thermometer values and thresholds in crystal periods
  logic [7:0] th [5] = '{8'h10, 8'h18, 8'h1c, 8'h1e, 8'h1f};
  int         lim [5] = '{2048, 8192, 16384, 32768, 65536};

  standby_ctl standby_ctl_inst (.clock(clock), .nrst(nrst), .halt_instr(halt_instr),
    .stop_instr(stop_instr), .irq_pending(irq_pending), .cpu_on_crystal(cpu_on_crystal),
    .cpu_on_main(cpu_on_main), .main_osc_stop(main_osc_stop),
    .crystal_running(crystal_running), .req(req), .rdata_q(rdata_q), .clk_q(clk_q),
    .wait_busy_q(wait_busy_q));

  // ----------------------------------------
  // Clock, timeout and closing
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // Full run is about 74k cycles; the ceiling leaves margin
  always @(posedge clock) begin
    cycles++;
    if (cycles == 90000) begin
      miscompares++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    if (miscompares == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ----------------------------------------
  // Compare, register read and write
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Read data is registered, so it is looked at one cycle later
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    req.rd = 1'b1;
    req.addr = a;
    @(negedge clock);
    chk(rdata_q, e);
    req.rd = 1'b0;
    @(negedge clock);
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    @(negedge clock);
    req.wr = 1'b0;
    @(negedge clock);
  endtask
  task automatic instr(input bit stop);
    if (stop) stop_instr = 1'b1;
    else halt_instr = 1'b1;
    @(negedge clock);
    stop_instr = 1'b0;
    halt_instr = 1'b0;
  endtask
  task automatic wake();
    irq_pending = 1'b1;
    @(negedge clock);
    irq_pending = 1'b0;
    @(negedge clock);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    int n;
    int t;
    {nrst, halt_instr, stop_instr, irq_pending, main_osc_stop} = 5'h00;
    {cpu_on_crystal, cpu_on_main, crystal_running} = 3'h7;
    req = '0;
    repeat (5) @(negedge clock);
    nrst = 1'b1;
    rd(16'hffa3, 8'h00);
    rd(16'hffa4, 8'h05);
    rd(16'hffa5, 8'h00);
    wr(16'hffa4, 8'hff);
    rd(16'hffa4, 8'h07);
    wr(16'hffa3, 8'hff);
    rd(16'hffa3, 8'h00);
    wr(16'hffa4, 8'h01);
    // Halt while on the subclock, then stop refused there
    cpu_on_main = 1'b0;
    instr(1'b0);
    chk(clk_q, 3'h3);
    wake();
    chk(clk_q, 3'h7);
    instr(1'b1);
    chk(clk_q, 3'h7);
    // Stop on crystal; no counting until it oscillates
    cpu_on_main = 1'b1;
    crystal_running = 1'b0;
    instr(1'b1);
    chk(clk_q, 3'h0);
    wake();
    repeat (3000) @(negedge clock);
    chk(wait_busy_q, 1'b1);
    crystal_running = 1'b1;
    n = 0;
    while (wait_busy_q === 1'b1 && n < 3000) begin
      @(negedge clock);
      n++;
    end
    chk(16'(n >= 2040 && n <= 2060), 16'h1);
    rd(16'hffa3, 8'h10);
    repeat (3000) @(negedge clock);
    rd(16'hffa3, 8'h10);
    main_osc_stop = 1'b1;
    @(negedge clock);
    main_osc_stop = 1'b0;
    rd(16'hffa3, 8'h00);
    // Internal clock run: status polled climbs in order
    cpu_on_crystal = 1'b0;
    wr(16'hffa4, 8'h05);
    instr(1'b1);
    wake();
    t = 0;
    for (int k = 0; k < 5; k++) begin
      repeat (lim[k] + 20 - t) @(negedge clock);
      rd(16'hffa3, th[k]);
      t = lim[k] + 22;
    end
    report_and_stop();
  end
endmodule
